// >>> include/bct_pkg.sv
// Package with register map, field positions and carrier types
package bct_pkg;
    localparam logic [7:0]  OFF_IO_TOP_HI   = 8'h32;
    localparam logic [7:0]  OFF_CAP_START   = 8'h34;
    localparam logic [7:0]  OFF_INT_SCRATCH = 8'h3c;
    localparam logic [7:0]  OFF_INT_PIN     = 8'h3d;
    localparam logic [7:0]  OFF_BRIDGE_EXT  = 8'h3e;
    localparam logic [15:0] RST_IO_TOP_HI   = 16'h0000;
    localparam logic [7:0]  CAP_START_VAL   = 8'h50;
    localparam logic [7:0]  RST_INT_SCRATCH = 8'hff;
    localparam logic [7:0]  INT_PIN_VAL     = 8'h00;
    localparam logic [15:0] RST_BRIDGE_EXT  = 16'h0000;
    localparam int          BIT_MSG_EN      = 11;
    localparam int          BIT_DISC_FLAG   = 10;
    localparam int          BIT_INTERVAL    = 9;
    localparam logic [19:0] IO_LOW_ONES     = 20'hfffff;
    localparam logic [19:0] IO_LOW_ZEROS    = 20'h00000;
    localparam int          LONG_EXP        = 15;
    localparam int          SHORT_EXP       = 10;
    localparam logic [15:0] LONG_COUNT      = 16'h8000;
    localparam logic [15:0] SHORT_COUNT     = 16'h0400;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } bct_cfg_req_t;

    typedef struct packed {
        logic        msg_valid;
        logic        msg_fatal;
    } bct_err_msg_t;
endpackage : bct_pkg

// >>> src/bct_discard_timer.sv
// Secondary discard timer for one pending delayed completion
`timescale 1ns/1ps
module bct_discard_timer
    import bct_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic at_head,
    input  wire logic repeated,
    input  wire logic short_sel,
    output logic      expired
);
    typedef struct packed {
        logic        run;
        logic [15:0] cnt;
        logic        expired;
    } bct_tmr_t;

    bct_tmr_t st;
    bct_tmr_t next_st;

    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        if (!st.run) begin
            if (at_head) begin
                next_st.run = 1'b1;
                next_st.cnt = short_sel ? SHORT_COUNT : LONG_COUNT;
            end
        end else if (repeated) begin
            next_st.run = 1'b0;
        end else if (st.cnt == 16'h0001) begin
            next_st.run = 1'b0;
            next_st.expired = 1'b1;
        end else begin
            next_st.cnt = st.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.expired;

    expiry_after_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.expired |-> $past(st.run))
        else $error("Expiry without a running timer");
endmodule : bct_discard_timer

// >>> src/bct_io_window.sv
// Combinational I/O forwarding window compare
`timescale 1ns/1ps
module bct_io_window
    import bct_pkg::*;
(
    input  wire logic [15:0] base_high,
    input  wire logic [15:0] top_high,
    input  wire logic [31:0] io_addr,
    output logic             in_window
);
    logic [35:0] bottom;
    logic [35:0] top;

    always_comb begin
        bottom = {base_high, IO_LOW_ZEROS};
        top = {top_high, IO_LOW_ONES};
        in_window = ({4'h0, io_addr} >= bottom) && ({4'h0, io_addr} <= top);
    end
endmodule : bct_io_window

// >>> src/bct_top.sv
// Bridge configuration header tail, offsets 32h to 3Eh
`timescale 1ns/1ps
//
// Contract
// - I/O is forwarded only up to the limit field with low bits all ones.
// - The window bottom uses the base field with low bits all zeros.
// - The capabilities pointer always reads 50h.
// - The interrupt line byte is plain storage resetting to FFh.
// - The interrupt pin byte reads 00h and ignores writes.
// - Secondary interrupts pass through to the primary side.
// - Bridge control bits 15:12 read zero and ignore writes.
// - With the enable set in conventional mode a discard sends a nonfatal or fatal message.
// - With the enable clear no message, unless AER is on and unmasked.
// - Severity is selectable only with AER; otherwise nonfatal.
// - The message enable applies only in conventional PCI mode.
// - The discard flag sets on a discard and stays until read-cleared.
// - The timer runs 2^15 clocks, or 2^10 with the select bit set.
// - The timer starts only when the completion reaches queue head.
module bct_top
    import bct_pkg::*;
#(
    parameter bit AER_PRESENT = 1'b1
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire bct_cfg_req_t cfg_req,
    input  wire logic [15:0]  io_base_high,
    input  wire logic [31:0]  io_addr,
    input  wire logic         io_req,
    input  wire logic         compl_at_head,
    input  wire logic         master_repeated,
    input  wire logic         conventional_mode,
    input  wire logic         aer_discard_mask,
    input  wire logic         aer_discard_fatal,
    input  wire logic [3:0]   sec_int_n,
    output logic [15:0]       cfg_rdata,
    output logic              cfg_rvalid,
    output logic              io_forward,
    output bct_err_msg_t      err_msg,
    output logic              discard_event,
    output logic [3:0]        pri_int_n
);
    typedef struct packed {
        logic [15:0]  io_top_high;
        logic [7:0]   int_scratch;
        logic         msg_en;
        logic         disc_flag;
        logic         interval_sel;
        logic [15:0]  rdata;
        logic         rvalid;
        logic         fwd;
        bct_err_msg_t msg;
        logic         disc;
        logic [3:0]   sint_s1;
        logic [3:0]   sint_s2;
        logic [3:0]   pint;
    } bct_state_t;

    bct_state_t st;
    bct_state_t next_st;
    logic       expired;
    logic       in_window;

    function automatic logic [15:0] merge_be(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
        merge_be = {be[1] ? new_v[15:8] : old_v[15:8],
                    be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : merge_be

    bct_discard_timer u_timer (
        .clk       (clk),
        .rst_n     (rst_n),
        .at_head   (compl_at_head),
        .repeated  (master_repeated),
        .short_sel (st.interval_sel),
        .expired   (expired)
    );

    bct_io_window u_window (
        .base_high (io_base_high),
        .top_high  (st.io_top_high),
        .io_addr   (io_addr),
        .in_window (in_window)
    );

    always_comb begin
        logic [15:0] ctl;
        logic        send;
        ctl = 16'h0000;
        send = 1'b0;
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.msg = '0;
        next_st.disc = expired;
        next_st.fwd = io_req && in_window;
        next_st.sint_s1 = sec_int_n;
        next_st.sint_s2 = st.sint_s1;
        next_st.pint = st.sint_s2;
        if (cfg_req.wr) begin
            case (cfg_req.addr)
                OFF_IO_TOP_HI: begin
                    next_st.io_top_high = merge_be(st.io_top_high,
                        cfg_req.wdata, cfg_req.be);
                end
                OFF_INT_SCRATCH: begin
                    if (cfg_req.be[0]) begin
                        next_st.int_scratch = cfg_req.wdata[7:0];
                    end
                end
                OFF_BRIDGE_EXT: begin
                    if (cfg_req.be[1]) begin
                        next_st.msg_en = cfg_req.wdata[BIT_MSG_EN];
                        next_st.interval_sel = cfg_req.wdata[BIT_INTERVAL];
                    end
                end
                // Capability and pin bytes are hardwired
                default: begin
                end
            endcase
        end
        ctl[BIT_MSG_EN] = st.msg_en;
        ctl[BIT_DISC_FLAG] = st.disc_flag;
        ctl[BIT_INTERVAL] = st.interval_sel;
        if (cfg_req.rd) begin
            next_st.rvalid = 1'b1;
            case (cfg_req.addr)
                OFF_IO_TOP_HI:   next_st.rdata = st.io_top_high;
                OFF_CAP_START:   next_st.rdata = {8'h00, CAP_START_VAL};
                OFF_INT_SCRATCH: next_st.rdata = {INT_PIN_VAL,
                                                  st.int_scratch};
                OFF_INT_PIN:     next_st.rdata = {8'h00, INT_PIN_VAL};
                OFF_BRIDGE_EXT:  next_st.rdata = ctl;
                default:         next_st.rdata = 16'h0000;
            endcase
            // Read clears the flag only for the high byte lane
            if (cfg_req.addr == OFF_BRIDGE_EXT && cfg_req.be[1]) begin
                next_st.disc_flag = 1'b0;
            end
        end
        // Set beats a same-cycle clear
        if (expired) begin
            next_st.disc_flag = 1'b1;
        end
        if (expired && conventional_mode) begin
            send = st.msg_en;
        end
        if (expired && AER_PRESENT && !aer_discard_mask) begin
            send = 1'b1;
        end
        next_st.msg.msg_valid = send;
        next_st.msg.msg_fatal = send && AER_PRESENT && aer_discard_fatal;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.io_top_high <= RST_IO_TOP_HI;
            st.int_scratch <= RST_INT_SCRATCH;
            st.sint_s1 <= 4'hf;
            st.sint_s2 <= 4'hf;
            st.pint <= 4'hf;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_rdata = st.rdata;
    assign cfg_rvalid = st.rvalid;
    assign io_forward = st.fwd;
    assign err_msg = st.msg;
    assign discard_event = st.disc;
    assign pri_int_n = st.pint;

    sequence cap_read_s;
        cfg_req.rd && cfg_req.addr == OFF_CAP_START;
    endsequence

    cap_ptr_const_a: assert property (@(posedge clk) disable iff (!rst_n)
        cap_read_s |=> cfg_rdata == 16'h0050)
        else $error("Capability pointer not 50h");
    pin_const_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_req.rd && cfg_req.addr == OFF_INT_PIN |=> cfg_rdata == 16'h0000)
        else $error("Interrupt pin not zero");
    ctl_top_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_rvalid |-> !(cfg_rdata[15:12] != 4'h0 && $past(cfg_req.addr)
            == OFF_BRIDGE_EXT))
        else $error("Bridge control top bits nonzero");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.disc_flag && !(cfg_req.rd && cfg_req.addr == OFF_BRIDGE_EXT)
        |=> st.disc_flag)
        else $error("Discard flag dropped without read");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        expired |=> st.disc_flag && discard_event)
        else $error("Discard flag not set");
    msg_on_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
        expired && conventional_mode && st.msg_en |=> err_msg.msg_valid)
        else $error("Missing error message");
    no_msg_a: assert property (@(posedge clk) disable iff (!rst_n)
        err_msg.msg_valid |-> $past(expired))
        else $error("Message without discard");
    fatal_needs_aer_a: assert property (@(posedge clk) disable iff (!rst_n)
        err_msg.msg_fatal |-> AER_PRESENT && err_msg.msg_valid)
        else $error("Fatal message without AER");
    int_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##3 pri_int_n == $past(sec_int_n, 3))
        else $error("Interrupt not passed through");
endmodule : bct_top

// >>> test/bct_rc_model.sv
// Root complex model issuing configuration accesses
`timescale 1ns/1ps
module bct_rc_model
    import bct_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] cfg_rdata,
    input  wire logic        cfg_rvalid,
    output bct_cfg_req_t     cfg_req
);
    initial cfg_req = '0;
    // Idle lines carry the inverse so stale values never match
    task automatic go(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic [1:0] b);
        @(posedge clk) cfg_req <= '{w, !w, a, d, b};
        @(posedge clk) cfg_req <= '{1'b0, 1'b0, ~a, ~d, ~b};
    endtask : go
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        int n;
        q = 'x;
        go(1'b0, a, 16'h0000, 2'b11);
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (cfg_rvalid === 1'b1) begin
                q = cfg_rdata;
                break;
            end
        end
    endtask : rd
endmodule : bct_rc_model

// >>> test/tb_bct_top.sv
// Self-checking bench for the configuration header tail
`timescale 1ns/1ps
module tb_bct_top
    import bct_pkg::*;
;
    logic clk = 0, rst_n = 0, io_req = 0, head = 0, rptd = 0;
    logic conv = 0, mask = 1, fatal = 0, io_forward, discard_event;
    logic [15:0] base = 0, cfg_rdata, q;
    logic [31:0] io_addr = 0;
    logic [3:0]  sec = 4'hf, pri;
    logic        cfg_rvalid;
    bct_cfg_req_t cfg_req;
    bct_err_msg_t err_msg;
    int fails = 0, n_checks = 0, cyc = 0, seed = 31, i;
    logic [3:0] cases [5] = '{4'b1110, 4'b0110, 4'b0100, 4'b1010,
                              4'b1111};
    always #50 clk = ~clk;
    bct_top uut (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .io_base_high(base), .io_addr(io_addr), .io_req(io_req),
        .compl_at_head(head), .master_repeated(rptd),
        .conventional_mode(conv), .aer_discard_mask(mask),
        .aer_discard_fatal(fatal), .sec_int_n(sec),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .io_forward(io_forward), .err_msg(err_msg),
        .discard_event(discard_event), .pri_int_n(pri));
    bct_rc_model rc (.clk(clk), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cfg_req(cfg_req));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    function automatic logic win(logic [31:0] a, logic [15:0] lim);
        return {4'h0, a} >= {base, 20'h00000} &&
               {4'h0, a} <= {lim, 20'hfffff};
    endfunction : win
    task automatic io_try(input logic [31:0] a, input logic [15:0] l);
        @(posedge clk) io_req <= 1'b1;
        io_addr <= a;
        @(posedge clk) io_req <= 1'b0;
        @(negedge clk) chk(io_forward, win(a, l));
    endtask : io_try
    // Case bits: message enable, conventional, mask, repeated
    task automatic disc(input logic [3:0] c);
        int n, at;
        logic ev, mv, fv, exm;
        ev = 0;
        mv = 0;
        fv = 0;
        at = 0;
        exm = !c[0] && ((c[2] && c[3]) || !c[1]);
        rc.go(1'b1, OFF_BRIDGE_EXT, {4'h0, c[3], 2'b01, 9'h0}, 2'b11);
        @(posedge clk) conv <= c[2];
        mask <= c[1];
        fatal <= 1'($random(seed));
        head <= 1'b1;
        @(posedge clk) head <= 1'b0;
        for (n = 0; n < 1100; n++) begin
            @(posedge clk) rptd <= c[0] && n == 500;
            if (discard_event === 1'b1 && !ev)
                at = n;
            if (discard_event === 1'b1)
                ev = 1;
            if (err_msg.msg_valid === 1'b1) begin
                mv = 1;
                fv = err_msg.msg_fatal;
            end
        end
        chk(ev, !c[0]);
        if (ev)
            chk(at >= 1020 && at <= 1030, 1'b1);
        chk(mv, exm);
        if (mv)
            chk(fv, fatal);
        rc.rd(OFF_BRIDGE_EXT, q);
        chk(q, {4'h0, c[3], ev, 1'b1, 9'h0});
        rc.rd(OFF_BRIDGE_EXT, q);
        chk(q, {4'h0, c[3], 2'b01, 9'h0});
    endtask : disc
    always @(posedge clk) begin
        cyc++;
        // Ceiling well above the five timer runs of about 1100 cycles
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        logic [15:0] v, l;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rc.rd(OFF_IO_TOP_HI, q);
        chk(q, RST_IO_TOP_HI);
        rc.rd(OFF_CAP_START, q);
        chk(q, 16'h0050);
        rc.rd(OFF_INT_SCRATCH, q);
        chk(q, 16'h00ff);
        rc.rd(OFF_INT_PIN, q);
        chk(q, 16'h0000);
        rc.rd(OFF_BRIDGE_EXT, q);
        chk(q, 16'h0000);
        v = 16'($random(seed));
        rc.go(1'b1, OFF_IO_TOP_HI, v, 2'b11);
        rc.rd(OFF_IO_TOP_HI, q);
        chk(q, v);
        rc.go(1'b1, OFF_CAP_START, 16'hffff, 2'b11);
        rc.rd(OFF_CAP_START, q);
        chk(q, 16'h0050);
        rc.go(1'b1, OFF_INT_SCRATCH, v, 2'b11);
        rc.rd(OFF_INT_SCRATCH, q);
        chk(q, {8'h00, v[7:0]});
        rc.go(1'b1, OFF_BRIDGE_EXT, 16'hffff, 2'b11);
        rc.rd(OFF_BRIDGE_EXT, q);
        chk(q, 16'h0a00);
        rc.rd(8'h36, q);
        chk(q, 16'h0000);
        $display("register test done");
        for (i = 0; i < 8; i++) begin
            base = 16'($random(seed)) & 16'h0fff;
            l = base + (16'($random(seed)) & 16'h00ff);
            rc.go(1'b1, OFF_IO_TOP_HI, l, 2'b11);
            io_try({l[11:0], 20'hfffff}, l);
            io_try({l[11:0], 20'hfffff} + 32'h1, l);
            io_try({base[11:0], 20'h00000}, l);
            io_try({base[11:0], 20'h00000} - 32'h1, l);
            io_try($random(seed), l);
        end
        $display("io window test done");
        for (i = 0; i < 4; i++) begin
            @(posedge clk) sec <= 4'($random(seed));
            repeat (4) @(posedge clk);
            chk(pri, sec);
        end
        $display("interrupt test done");
        for (i = 0; i < 5; i++)
            disc(cases[i]);
        $display("discard test done");
        wrap_up();
    end
endmodule : tb_bct_top
